// [tcb_top.sv]
/*
 * terminal configuration bank: first configuration register low bits
 * and second configuration register, with pin mirrors, address latch,
 * gap extension, gap check, broadcast gate and response timer.
 * assumes an apb master on core_clk and pins synchronous to core_clk.
 */
`timescale 1ns/1ps
module tcb_top #(
    parameter int unsigned RTRT_130_CYC = tcb_pkg::TO3_CYC
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,

    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,

    // device pins
    input  wire logic        single_ended_pin,
    input  wire logic        tx_block_a_pin,
    input  wire logic        tx_block_b_pin,
    input  wire logic        addr_latch_pin,

    // protocol engine events
    input  wire logic        monitor_mode,
    input  wire logic        next_msg_alt_bus,
    input  wire logic        msg_done,
    input  wire logic        msg_gap_short,
    input  wire logic        cmd_valid,
    input  wire logic [4:0]  cmd_addr,
    input  wire logic        resp_wait_start,
    input  wire logic        resp_seen,

    // configuration outputs
    output logic      [2:0]  test_mode_sel,
    output logic             dual_edge_sample,
    output logic             gap_check_enable,
    output logic             broadcast_disable,
    output logic             clock_choice,
    output logic      [4:0]  terminal_address,
    output logic             terminal_address_parity,

    // derived outputs
    output logic      [9:0]  gap_extra_cyc,
    output logic             msg_invalid,
    output logic             bcast_cmd,
    output logic             resp_timeout
);
    // carrier to the latch and the timer
    // keeps field wiring out of port lists
    tcb_cfg_if cfg_if ();

    // register storage
    logic [15:0] cfg4_reg;     // first configuration register
    logic [4:0]  cfg5_ctl_reg; // dual edge, timeout, gap, broadcast
    logic        clk_reg;      // clock choice bit

    // apb answer flops
    logic [31:0] prdata_reg;   // read data
    logic        pready_reg;   // access phase answer
    logic        pslverr_reg;  // unmapped address flag

    // event result flops
    logic [9:0]  gap_extra_reg; // added gap cycles
    logic        msg_inv_reg;  // invalid message pulse
    logic        bcast_reg;    // broadcast command pulse

    // address decode
    logic        sel_cfg4;     // first configuration register
    logic        sel_cfg5;     // second configuration register
    logic        sel_clk;      // clock choice register
    logic        mapped;       // any register hit

    // apb phases
    logic        acc_first;    // first access-phase cycle
    logic        acc_done;     // completing edge

    // write strobes
    logic        wr_cfg4;      // write strobe, first register
    logic        wr_cfg5;      // write strobe, second register
    logic        wr_clk;       // write strobe, clock register

    // read path
    logic [15:0] cfg5_view;    // read view of second register
    logic [31:0] rd_mux;       // read data selection

    // control field views
    logic        gap_keep;     // monitor gap extension field
    logic [1:0]  to_sel;       // timeout select field
    logic        gap_chk;      // gap check field
    logic        bcst_dis;     // broadcast disable field
    logic        dual_edge;    // dual edge sampling field

    // event gating
    logic        gap_add_now;  // extension applies this cycle
    logic        is_bcast;     // broadcast address seen

    // decode; only whole 32-bit words are mapped
    // low address bits must be zero to hit
    assign sel_cfg4 = (paddr == tcb_pkg::ADDR_CFG4);
    assign sel_cfg5 = (paddr == tcb_pkg::ADDR_CFG5);
    assign sel_clk = (paddr == tcb_pkg::ADDR_CLK);
    assign mapped = sel_cfg4 | sel_cfg5 | sel_clk;

    // one wait state: pready rises in the second access cycle
    // gives the read mux a full cycle to settle
    assign acc_first = psel & penable & ~pready_reg;
    assign acc_done = psel & penable & pready_reg;

    // writes land only on the completing edge
    // a long access never writes twice
    assign wr_cfg4 = acc_done & pwrite & sel_cfg4;
    assign wr_cfg5 = acc_done & pwrite & sel_cfg5;
    assign wr_clk = acc_done & pwrite & sel_clk;

    // field views
    assign gap_keep = cfg4_reg[tcb_pkg::GAP_KEEP_BIT];
    assign dual_edge = cfg5_ctl_reg[4];
    assign to_sel = cfg5_ctl_reg[3:2];
    assign gap_chk = cfg5_ctl_reg[1];
    assign bcst_dis = cfg5_ctl_reg[0];

    // mirrors are live levels, read-only
    // writes to these bits are dropped
    assign cfg5_view = {clk_reg,
                        single_ended_pin,
                        tx_block_a_pin,
                        tx_block_b_pin,
                        cfg5_ctl_reg,
                        addr_latch_pin,
                        cfg_if.addr_latched};

    // read mux; unmapped reads return zero
    // upper half of every word reads zero
    assign rd_mux = sel_cfg4 ? {16'h0000, cfg4_reg} :
                    sel_cfg5 ? {16'h0000, cfg5_view} :
                    sel_clk  ? {31'h00000000, clk_reg} : 32'h00000000;

    // latch carrier; written bits 5-0 go to staging
    // the latch decides when they go live
    assign cfg_if.latch_en = cfg4_reg[tcb_pkg::LATCH_EN_BIT];
    assign cfg_if.stage_wr = wr_cfg5;
    assign cfg_if.stage_data = pwdata[tcb_pkg::ADDR_MSB:0];
    assign cfg_if.latch_pin = addr_latch_pin;

    // timer carrier
    // longest count is a parameter for short sims
    assign cfg_if.to_sel = to_sel;
    assign cfg_if.to_long_cyc = RTRT_130_CYC[12:0];
    assign cfg_if.resp_start = resp_wait_start;
    assign cfg_if.resp_seen = resp_seen;

    // event qualifiers
    // both decode straight from field flops
    assign gap_add_now = monitor_mode & ~gap_keep & next_msg_alt_bus;
    assign is_bcast = cmd_valid & (cmd_addr == tcb_pkg::BCAST_ADDR) & ~bcst_dis;

    // outputs, all from flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // configuration outputs
    assign test_mode_sel = cfg4_reg[tcb_pkg::TEST_MSB:0];
    assign dual_edge_sample = dual_edge;
    assign gap_check_enable = gap_chk;
    assign broadcast_disable = bcst_dis;
    assign clock_choice = clk_reg;
    assign terminal_address = cfg_if.addr_latched[5:1];
    assign terminal_address_parity = cfg_if.addr_latched[0];

    // derived outputs
    assign gap_extra_cyc = gap_extra_reg;
    assign msg_invalid = msg_inv_reg;
    assign bcast_cmd = bcast_reg;
    assign resp_timeout = cfg_if.resp_tout;

    // apb answer: data and error sampled in the first access cycle
    // prdata holds until the next read
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= acc_first;
            pslverr_reg <= acc_first & ~mapped;
            if (acc_first & ~pwrite) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    // first register; test codes stored as written
    // reserved codes kept; host avoids them
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg4_reg <= tcb_pkg::CFG4_RST;
        end else if (wr_cfg4) begin
            cfg4_reg <= pwdata[15:0];
        end
    end

    // second register: only bits 11-7 are stored here
    // mirrors and address need no flops here
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg5_ctl_reg <= tcb_pkg::CFG5_RST;
        end else if (wr_cfg5) begin
            cfg5_ctl_reg <= pwdata[tcb_pkg::DUAL_BIT:tcb_pkg::BCST_DIS_BIT];
        end
    end

    // clock choice register
    // also shows in bit 15 of second register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_reg <= tcb_pkg::CLK_RST;
        end else if (wr_clk) begin
            clk_reg <= pwdata[tcb_pkg::CLK_SEL_BIT];
        end
    end

    // monitor gap extension, registered per cycle
    // level based, so nothing piles up
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_extra_reg <= 10'h000;
        end else begin
            gap_extra_reg <= gap_add_now ? tcb_pkg::GAP_ADD_CYC : 10'h000;
        end
    end

    // gap check and broadcast recognition pulses
    // one-cycle pulses a cycle after the event
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            msg_inv_reg <= 1'b0;
            bcast_reg <= 1'b0;
        end else begin
            msg_inv_reg <= msg_done & msg_gap_short & gap_chk;
            bcast_reg <= is_bcast;
        end
    end

    // address latch and response timer
    // each sees the carrier through its modport
    tcb_addr_latch u_latch (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .cfg      (cfg_if.latch)
    );

    tcb_resp_timer u_timer (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .cfg      (cfg_if.timer)
    );

    // checks on the register bank and its outputs
    // pulses are judged a cycle after their cause
    chk_gap_extend: assert property (@(posedge core_clk) disable iff (!reset_n)
        (monitor_mode && !gap_keep && next_msg_alt_bus)
        |=> gap_extra_cyc == tcb_pkg::GAP_ADD_CYC)
        else $error("gap extension missing");

    chk_gap_keep: assert property (@(posedge core_clk) disable iff (!reset_n)
        (gap_keep || !monitor_mode)
        |=> gap_extra_cyc == 10'h000)
        else $error("gap extended while disabled");

    chk_test_write: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_cfg4
        |=> test_mode_sel == $past(pwdata[2:0]))
        else $error("test select not written");

    chk_clk_mirror: assert property (@(posedge core_clk) disable iff (!reset_n)
        (acc_first && !pwrite && sel_cfg5)
        |=> prdata[15] == $past(clk_reg))
        else $error("clock mirror wrong");

    chk_se_mirror: assert property (@(posedge core_clk) disable iff (!reset_n)
        (acc_first && !pwrite && sel_cfg5)
        |=> prdata[14] == $past(single_ended_pin))
        else $error("single-ended mirror wrong");

    chk_txa_mirror: assert property (@(posedge core_clk) disable iff (!reset_n)
        (acc_first && !pwrite && sel_cfg5)
        |=> prdata[13] == $past(tx_block_a_pin))
        else $error("bus A inhibit mirror wrong");

    chk_txb_mirror: assert property (@(posedge core_clk) disable iff (!reset_n)
        (acc_first && !pwrite && sel_cfg5)
        |=> prdata[12] == $past(tx_block_b_pin))
        else $error("bus B inhibit mirror wrong");

    chk_dual_write: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_cfg5
        |=> dual_edge_sample == $past(pwdata[11]))
        else $error("dual edge field not written");

    chk_gap_invalid: assert property (@(posedge core_clk) disable iff (!reset_n)
        (msg_done && msg_gap_short)
        |=> msg_invalid == $past(gap_chk))
        else $error("gap check result wrong");

    chk_bcast_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cmd_valid && cmd_addr == 5'h1F)
        |=> bcast_cmd == !$past(bcst_dis))
        else $error("broadcast gating wrong");

    chk_latch_mirror: assert property (@(posedge core_clk) disable iff (!reset_n)
        (acc_first && !pwrite && sel_cfg5)
        |=> prdata[6] == $past(addr_latch_pin))
        else $error("latch pin mirror wrong");

    chk_apb_answer: assert property (@(posedge core_clk) disable iff (!reset_n)
        acc_first
        |=> pready ##1 !pready)
        else $error("apb answer not one cycle");
endmodule

// [tcb_pkg.sv]
/*
 * shared constants for the terminal configuration bank: register
 * indices, field positions, reset values, test codes and timing counts.
 * assumes a 40 MHz core clock and a 32-bit apb register bus.
 */
package tcb_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0]  IDX_CFG4  = 10'h008;
    localparam logic [9:0]  IDX_CFG5  = 10'h009;
    localparam logic [9:0]  IDX_CLK   = 10'h010;
    localparam logic [11:0] ADDR_CFG4 = {IDX_CFG4, 2'b00};
    localparam logic [11:0] ADDR_CFG5 = {IDX_CFG5, 2'b00};
    localparam logic [11:0] ADDR_CLK  = {IDX_CLK, 2'b00};
    // reset values
    localparam logic [15:0] CFG4_RST  = 16'h0000;
    localparam logic [4:0]  CFG5_RST  = 5'h00;
    localparam logic [5:0]  ADDR_RST  = 6'h00;
    localparam logic        CLK_RST   = 1'b0;
    // first configuration register fields
    localparam int unsigned GAP_KEEP_BIT = 4;
    localparam int unsigned LATCH_EN_BIT = 3;
    localparam int unsigned TEST_MSB     = 2;
    // second configuration and clock register fields
    localparam int unsigned CLK_MIR_BIT  = 15;
    localparam int unsigned SE_MIR_BIT   = 14;
    localparam int unsigned TXA_MIR_BIT  = 13;
    localparam int unsigned TXB_MIR_BIT  = 12;
    localparam int unsigned DUAL_BIT     = 11;
    localparam int unsigned TO_MSB       = 10;
    localparam int unsigned TO_LSB       = 9;
    localparam int unsigned GAP_CHK_BIT  = 8;
    localparam int unsigned BCST_DIS_BIT = 7;
    localparam int unsigned LATCH_MIR_BIT = 6;
    localparam int unsigned ADDR_MSB     = 5;
    localparam int unsigned CLK_SEL_BIT  = 0;
    // test select codes
    localparam logic [2:0]  TEST_NORMAL  = 3'h0;
    localparam logic [2:0]  TEST_DECODER = 3'h1;
    localparam logic [2:0]  TEST_ENCODER = 3'h2;
    localparam logic [2:0]  TEST_PROTO   = 3'h3;
    localparam logic [2:0]  TEST_FSAFE   = 3'h4;
    localparam logic [2:0]  TEST_REGS    = 3'h5;
    // broadcast terminal address
    localparam logic [4:0]  BCAST_ADDR   = 5'h1F;
    // timing, times in ns
    localparam int unsigned CLK_NS       = 25;
    localparam int unsigned GAP_ADD_NS   = 20000;
    localparam int unsigned TO0_NS       = 18500;
    localparam int unsigned TO1_NS       = 22500;
    localparam int unsigned TO2_NS       = 50500;
    localparam int unsigned TO3_NS       = 130000;
    localparam int unsigned CNT_W        = 13;
    localparam logic [9:0]  GAP_ADD_CYC  = 10'(GAP_ADD_NS / CLK_NS);
    localparam logic [12:0] TO0_CYC      = 13'(TO0_NS / CLK_NS);
    localparam logic [12:0] TO1_CYC      = 13'(TO1_NS / CLK_NS);
    localparam logic [12:0] TO2_CYC      = 13'(TO2_NS / CLK_NS);
    localparam int unsigned TO3_CYC      = TO3_NS / CLK_NS;
endpackage

// [tcb_cfg_if.sv]
/*
 * carrier between the top of the configuration bank and its address
 * latch and response timer. assumes all users share core_clk.
 */
`timescale 1ns/1ps
interface tcb_cfg_if;
    logic        latch_en;     // latch enable field
    logic        stage_wr;     // host wrote address bits
    logic [5:0]  stage_data;   // written address and parity
    logic        latch_pin;    // address-latch input level
    logic [5:0]  addr_latched; // latched address and parity
    logic [1:0]  to_sel;       // timeout select field
    logic [12:0] to_long_cyc;  // count for the longest timeout
    logic        resp_start;   // start waiting for a response
    logic        resp_seen;    // response arrived
    logic        resp_tout;    // timeout pulse
    modport top (output latch_en, stage_wr, stage_data, latch_pin, to_sel,
                 to_long_cyc, resp_start, resp_seen,
                 input addr_latched, resp_tout);
    modport latch (input latch_en, stage_wr, stage_data, latch_pin,
                   output addr_latched);
    modport timer (input to_sel, to_long_cyc, resp_start, resp_seen,
                   output resp_tout);
endinterface

// [tcb_addr_latch.sv]
/*
 * terminal address and parity latch. holds the last host-written value
 * and copies it into the live address only while enabled by both the
 * register field and the latch pin. assumes pins synchronous to core_clk.
 */
`timescale 1ns/1ps
module tcb_addr_latch (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // configuration carrier
    tcb_cfg_if.latch  cfg
);
    logic [5:0] stage_reg;  // last written value
    logic [5:0] stage_next; // includes a write in this cycle
    logic [5:0] addr_reg;   // live address and parity
    logic       open_gate;  // both enables high

    // a write in the same cycle as the gate is taken at once
    assign stage_next = cfg.stage_wr ? cfg.stage_data : stage_reg;
    assign open_gate = cfg.latch_en & cfg.latch_pin;
    assign cfg.addr_latched = addr_reg;

    // staging and latch flops
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage_reg <= tcb_pkg::ADDR_RST;
            addr_reg <= tcb_pkg::ADDR_RST;
        end else begin
            stage_reg <= stage_next;
            if (open_gate) begin
                addr_reg <= stage_next;
            end
        end
    end

    chk_latch_closed: assert property (@(posedge core_clk) disable iff (!reset_n)
        !(cfg.latch_en && cfg.latch_pin) |=> $stable(addr_reg))
        else $error("address moved with latch closed");
    chk_latch_capture: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cfg.latch_en && cfg.latch_pin && cfg.stage_wr) |=> addr_reg == $past(cfg.stage_data))
        else $error("address not captured from write");
endmodule

// [tcb_resp_timer.sv]
/*
 * remote-to-remote response timer. a start pulse loads the selected
 * count; a response stops it; expiry gives a one-cycle timeout pulse.
 * assumes start and seen are one-cycle pulses on core_clk.
 */
`timescale 1ns/1ps
module tcb_resp_timer (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // configuration carrier
    tcb_cfg_if.timer  cfg
);
    typedef enum logic {TCB_IDLE, TCB_RUN} tcb_tmr_e;
    tcb_tmr_e    st_reg;     // timer state
    logic [12:0] cnt_reg;    // cycles left
    logic [12:0] load_cyc;   // selected count
    logic        tout_reg;   // timeout pulse
    logic [12:0] elapsed;    // helper for checking
    logic [12:0] cap_cyc;    // helper: count at start

    // count for each select code
    assign load_cyc = (cfg.to_sel == 2'b00) ? tcb_pkg::TO0_CYC :
                      (cfg.to_sel == 2'b01) ? tcb_pkg::TO1_CYC :
                      (cfg.to_sel == 2'b10) ? tcb_pkg::TO2_CYC : cfg.to_long_cyc;
    assign cfg.resp_tout = tout_reg;

    // timer; a new start restarts the count
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= TCB_IDLE;
            cnt_reg <= 13'h0000;
            tout_reg <= 1'b0;
        end else begin
            tout_reg <= 1'b0;
            case (st_reg)
                TCB_IDLE: begin
                    if (cfg.resp_start) begin
                        cnt_reg <= load_cyc;
                        st_reg <= TCB_RUN;
                    end
                end
                TCB_RUN: begin
                    if (cfg.resp_start) begin
                        cnt_reg <= load_cyc;
                    end else if (cfg.resp_seen) begin
                        st_reg <= TCB_IDLE;
                    end else if (cnt_reg <= 13'h0001) begin
                        tout_reg <= 1'b1;
                        st_reg <= TCB_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 13'h0001;
                    end
                end
                default: st_reg <= TCB_IDLE;
            endcase
        end
    end

    // helper counting cycles since the last start
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            elapsed <= 13'h0000;
            cap_cyc <= 13'h0000;
        end else if (cfg.resp_start) begin
            elapsed <= 13'h0001;
            cap_cyc <= load_cyc;
        end else if (elapsed != 13'h1FFF) begin
            elapsed <= elapsed + 13'h0001;
        end
    end

    chk_timeout_span: assert property (@(posedge core_clk) disable iff (!reset_n)
        tout_reg |-> elapsed == cap_cyc + 13'h0001)
        else $error("timeout fired at wrong count");
endmodule

// [tcb_host.sv]
/*
 * apb host model for the configuration bank: one transfer task.
 * assumes a slave on core_clk that answers with pready.
 */
`timescale 1ns/1ps
module tcb_host (
    // clock
    input  wire logic        core_clk,
    // apb master side
    output logic      [11:0] paddr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic [31:0] rdat; // data of the last transfer
    logic        rerr; // error flag of the last transfer
    // bus idle at time zero
    initial begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // one transfer; an idle cycle always comes before the setup
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // no fixed wait count: the bench watchdog cuts a hang
        do @(posedge core_clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // released bus must not keep the word
    endtask
endmodule

// [tcb_tb_top.sv]
/*
 * self-checking bench for the configuration bank.
 * assumes the host model drives apb; pins and events come from here.
 */
`timescale 1ns/1ps
module tcb_tb_top;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] paddr;
    logic psel, penable, pwrite, pready, pslverr;
    logic [31:0] pwdata, prdata, v;
    logic se, txa, txb, alp, mon, alt, mdone, gshort, cval, rstart, rseen;
    logic [4:0] caddr, terminal_address;
    logic [2:0] test_mode_sel;
    logic [9:0] gap_extra_cyc;
    logic [5:0] a;
    logic dual_edge_sample, gap_check_enable, broadcast_disable, clock_choice;
    logic terminal_address_parity, msg_invalid, bcast_cmd, resp_timeout;
    int error_cnt = 0;
    int cmp_count = 0;
    int n;
    int tmo[4] = '{740, 900, 2020, 40}; // timeout counts at 25 ns
    always #12.5 core_clk = ~core_clk;
    // short longest timeout keeps the run brief
    tcb_top #(.RTRT_130_CYC(40)) i_tcb_top (.core_clk, .reset_n, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .single_ended_pin(se), .tx_block_a_pin(txa), .tx_block_b_pin(txb),
        .addr_latch_pin(alp), .monitor_mode(mon), .next_msg_alt_bus(alt),
        .msg_done(mdone), .msg_gap_short(gshort), .cmd_valid(cval), .cmd_addr(caddr),
        .resp_wait_start(rstart), .resp_seen(rseen), .test_mode_sel, .dual_edge_sample,
        .gap_check_enable, .broadcast_disable, .clock_choice, .terminal_address,
        .terminal_address_parity, .gap_extra_cyc, .msg_invalid, .bcast_cmd, .resp_timeout);
    tcb_host i_tcb_host (.core_clk, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr);
    // compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // read a word and compare data and error flag
    task automatic rd(input logic [11:0] ad, input logic [31:0] e, input logic er);
        i_tcb_host.xfer(1'b0, ad, 32'h0);
        chk(i_tcb_host.rdat, e);
        chk({31'h0, i_tcb_host.rerr}, {31'h0, er});
    endtask
    // expected second register: mirrors, stored bits, latched address
    function automatic logic [31:0] exp5(input logic c, input logic [4:0] rw);
        return {16'h0, c, se, txa, txb, rw, alp, a};
    endfunction
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog: the tests need about 7000 cycles
    initial begin
        #(25 * 40000);
        error_cnt++;
        print_verdict();
    end
    initial begin
        {se, txa, txb, alp, mon, alt, mdone, gshort, cval, rstart, rseen} = 11'h0;
        caddr = 5'h00;
        a = 6'h00;
        v = $urandom(38);
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(tcb_pkg::ADDR_CFG4, 32'h0, 1'b0);
        rd(tcb_pkg::ADDR_CFG5, 32'h0, 1'b0);
        rd(12'h030, 32'h0, 1'b1);
        $display("reset test done");
        // every test code the host may use
        for (int i = 0; i < 6; i++) begin
            i_tcb_host.xfer(1'b1, tcb_pkg::ADDR_CFG4, 32'(i));
            #1 chk(32'(test_mode_sel), 32'(i));
        end
        // random mirrors and stored bits, latch closed
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            {se, txa, txb, alp} <= v[31:28];
            i_tcb_host.xfer(1'b1, tcb_pkg::ADDR_CLK, {31'h0, v[27]});
            i_tcb_host.xfer(1'b1, tcb_pkg::ADDR_CFG5, v);
            #1 chk({29'h0, dual_edge_sample, gap_check_enable, broadcast_disable},
                {29'h0, v[11], v[8], v[7]});
            chk({31'h0, clock_choice}, {31'h0, v[27]});
            rd(tcb_pkg::ADDR_CFG5, exp5(v[27], v[11:7]), 1'b0);
        end
        $display("mirror test done");
        // staged address only lands with field and pin both high
        alp <= 1'b1;
        i_tcb_host.xfer(1'b1, tcb_pkg::ADDR_CFG5, {26'h0, v[5:0]});
        #1 chk({26'h0, terminal_address, terminal_address_parity}, 32'h0);
        i_tcb_host.xfer(1'b1, tcb_pkg::ADDR_CFG4, 32'h8);
        repeat (2) @(posedge core_clk);
        a = v[5:0];
        chk({26'h0, terminal_address, terminal_address_parity}, {26'h0, a});
        rd(tcb_pkg::ADDR_CFG5, exp5(v[27], 5'h00), 1'b0);
        $display("latch test done");
        // gap extension on and off
        mon <= 1'b1;
        alt <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1 chk(32'(gap_extra_cyc), tcb_pkg::GAP_ADD_NS / tcb_pkg::CLK_NS);
        i_tcb_host.xfer(1'b1, tcb_pkg::ADDR_CFG4, 32'h18);
        repeat (2) @(posedge core_clk);
        #1 chk(32'(gap_extra_cyc), 32'h0);
        // gap check and broadcast gate, enabled then disabled
        for (int k = 0; k < 2; k++) begin
            i_tcb_host.xfer(1'b1, tcb_pkg::ADDR_CFG5, (k ? 32'h80 : 32'h100) | a);
            {mdone, gshort, cval} <= 3'h7;
            caddr <= 5'h1F;
            @(posedge core_clk);
            {mdone, cval} <= 2'h0;
            #1 chk({31'h0, msg_invalid}, 32'(k == 0));
            chk({31'h0, bcast_cmd}, 32'(k == 0));
        end
        $display("event test done");
        // each response timeout, then a cancelled wait
        for (int k = 0; k < 5; k++) begin
            i_tcb_host.xfer(1'b1, tcb_pkg::ADDR_CFG5, (32'(k % 4) << 9) | a);
            rstart <= 1'b1;
            @(posedge core_clk);
            rstart <= 1'b0;
            rseen <= (k == 4);
            n = 0;
            do begin
                @(posedge core_clk);
                rseen <= 1'b0;
                n++;
                #1;
            end while (resp_timeout !== 1'b1 && n < 3000);
            chk(32'(n), k < 4 ? 32'(tmo[k]) : 32'd3000);
        end
        $display("timer test done");
        print_verdict();
    end
endmodule
